// File: hdl/lcdc_pkg.sv
package lcdc_pkg;
    // Bus and memory geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 4;
    localparam int NUM_COM = 4;
    localparam int NUM_SEG = 38;
    localparam int NUM_PAIRS = 19;
    localparam int MEM_WORDS = 48;
    localparam int MAP_W = 8;
    // Drive switch register
    localparam logic [7:0] SWITCH_ADDR = 8'h78;
    localparam int SWITCH_DRIVE_BIT = 3;
    localparam logic [3:0] SWITCH_RESET = 4'h0;
    // Display memory windows
    localparam logic [7:0] MEM_LOW_BASE = 8'h40;
    localparam logic [7:0] MEM_LOW_LAST = 8'h6F;
    localparam logic [7:0] MEM_HIGH_BASE = 8'hC0;
    localparam logic [7:0] MEM_HIGH_LAST = 8'hEF;
    // Frame divisors of the slow oscillator
    localparam int FRAME_DIV_4 = 1024;
    localparam int FRAME_DIV_3 = 768;
    localparam int FRAME_DIV_2 = 1024;
    // Read data for undefined reads
    localparam logic [3:0] UNDEF_READ = 4'h0;
    // All-off output level
    localparam logic OFF_LEVEL = 1'b0;
endpackage

// File: hdl/lcdc_slot_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Steps through common slots in equal parts of one frame
module lcdc_slot_timer #(
    parameter int DUTY = 4,
    parameter int FRAME_DIV = 1024
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic run_i,
    // Slot state
    output logic [1:0] slot_o,
    output logic frame_o
);
    localparam int SLOT_LEN = FRAME_DIV / DUTY;
    localparam logic [9:0] SLOT_LAST = 10'(SLOT_LEN - 1);
    localparam logic [1:0] SLOT_MAX = 2'(DUTY - 1);

    logic [9:0] cnt_reg; // Cycle count within slot
    logic [1:0] slot_reg; // Current common
    logic frame_reg; // Frame start pulse
    wire slot_end = (cnt_reg == SLOT_LAST);
    wire frame_end = slot_end && (slot_reg == SLOT_MAX);

    // Equal slot lengths; held at slot 0 while all-off
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 10'h000;
            slot_reg <= 2'h0;
            frame_reg <= 1'b0;
        end else if (!run_i) begin
            cnt_reg <= 10'h000;
            slot_reg <= 2'h0;
            frame_reg <= 1'b0;
        end else begin
            cnt_reg <= slot_end ? 10'h000 : cnt_reg + 10'h001;
            if (slot_end) begin
                slot_reg <= frame_end ? 2'h0 : slot_reg + 2'h1;
            end
            frame_reg <= frame_end;
        end
    end

    assign slot_o = slot_reg;
    assign frame_o = frame_reg;
endmodule
`default_nettype wire

// File: hdl/lcdc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Four commons, 38 segments, 152 segments
// - Frame is clock over 1024, or 768
// - Duty 1/4, 1/3 or 1/2 build choice
// - Bit 3 at 78H selects drive, reads back
// - All-off holds every non-DC output constant
// - Reset clears drive bit to all-off
// - Memory one lights segment, zero off
// - Memory window 40H-6FH or C0H-EFH only
// - Low window readable, high window write-only
// - Display memory not cleared by reset
// - Bit to pin and common map buildable
// - DC pin drives its common 0 bit
// - DC choice per pin pair; drive type
module lcdc_top #(
    parameter int DUTY = 4,
    parameter bit HIGH_WINDOW = 1'b0,
    // Per pair: 1 selects DC output
    parameter logic [18:0] DC_PAIRS = 19'h00000,
    // Per pin: 1 selects open drain when DC
    parameter logic [37:0] DC_OPEN_DRAIN = 38'h0000000000,
    // Map: {word[5:0],bit[1:0]} per pin and common, default linear
    parameter logic [151:0][7:0] SEG_MAP = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // CPU data bus
    input wire logic [7:0] cpu_addr_i,
    input wire logic [3:0] cpu_wdata_i,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    output logic [3:0] cpu_rdata_o,
    output logic cpu_hit_o,
    // Panel
    output logic [3:0] common_outputs_o,
    output logic [3:0] common_active_o,
    output logic [37:0] segment_outputs_o,
    output logic [37:0] segment_oe_n_o,
    output logic [37:0] segment_dc_o,
    // Clock timer mask bits kept for the timer block
    output logic [2:0] tick_irq_en_o
);
    // Derived build constants: frame divisor by duty and window bounds
    localparam int FRAME_DIV = (DUTY == 3) ? lcdc_pkg::FRAME_DIV_3 :
        (DUTY == 2) ? lcdc_pkg::FRAME_DIV_2 : lcdc_pkg::FRAME_DIV_4;
    localparam logic [7:0] BASE = HIGH_WINDOW ? lcdc_pkg::MEM_HIGH_BASE :
        lcdc_pkg::MEM_LOW_BASE;
    localparam logic [7:0] LAST = HIGH_WINDOW ? lcdc_pkg::MEM_HIGH_LAST :
        lcdc_pkg::MEM_LOW_LAST;

    // The CPU bus runs on the same slow clock as the panel logic, so no
    // synchroniser sits on the address, data or strobes. A faster CPU
    // clock would need a handshake in front of this block.
    // Switch register: drive bit plus three tick masks
    logic [3:0] switch_reg;
    logic [3:0] switch_next;
    // Display memory, 48 words of 4 bits, no reset
    logic [3:0] mem [0:47];
    // Registered read data
    logic [3:0] rdata_reg;
    logic [3:0] rdata_next;
    // Registered panel outputs
    logic [3:0] com_reg;
    logic [37:0] seg_reg;
    logic [37:0] seg_next;
    logic [3:0] com_next;

    // Address decode. The switch register and the display window are the
    // only targets; every other address reads as the undefined value and
    // ignores writes.
    wire sw_hit = (cpu_addr_i == lcdc_pkg::SWITCH_ADDR);
    wire mem_hit = (cpu_addr_i >= BASE) && (cpu_addr_i <= LAST);
    wire [5:0] mem_idx = 6'(cpu_addr_i - BASE);
    // Write qualifiers, one per target, and a read qualifier for the memory only
    wire sw_wr = cpu_wr_i && sw_hit;
    wire mem_wr = cpu_wr_i && mem_hit;
    // High window is write-only, so its reads take the default value
    wire mem_rd_ok = mem_hit && !HIGH_WINDOW;
    wire drive_on = switch_reg[lcdc_pkg::SWITCH_DRIVE_BIT];
    wire [1:0] slot;

    assign switch_next = sw_wr ? cpu_wdata_i : switch_reg;

    // Bits 2..0 are only stored here and handed to the timer block; the
    // drive bit alone steers the panel logic below.
    // Switch register; reset selects all-off
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            switch_reg <= lcdc_pkg::SWITCH_RESET;
        end else begin
            switch_reg <= switch_next;
        end
    end

    // No reset branch on purpose: the array maps onto plain storage and
    // software must fill it before the panel shows anything meaningful.
    // Writes outside the window are dropped; cpu_hit_o stays low for them unless they hit 78H.
    // Memory write; contents undefined after reset
    always_ff @(posedge clk_i) begin
        if (mem_wr) begin
            mem[mem_idx] <= cpu_wdata_i;
        end
    end

    // Switch register wins if both decoders ever overlapped; they cannot
    // with the two windows, but the order keeps the result defined.
    // Read mux; high window reads are undefined
    always_comb begin
        rdata_next = lcdc_pkg::UNDEF_READ;
        if (sw_hit) begin
            rdata_next = switch_reg;
        end else if (mem_rd_ok) begin
            rdata_next = mem[mem_idx];
        end
    end

    // The read value is captured only on a read strobe, so the output
    // holds its last value between reads and never follows the address.
    // Read data registered for one cycle latency
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_reg <= 4'h0;
        end else if (cpu_rd_i) begin
            rdata_reg <= rdata_next;
        end
    end

    // Bus outputs: hit is combinational so the CPU side can qualify a
    // cycle without waiting; read data comes straight from its flop.
    assign cpu_rdata_o = rdata_reg;
    assign cpu_hit_o = sw_hit || mem_hit;
    assign tick_irq_en_o = switch_reg[2:0];

    // The slot timer sits at slot 0 while drive is off, so turning drive
    // on always starts a fresh frame with common 0 and a full first slot.
    // Its frame pulse is not needed here and is left open.
    // Slot sequencer
    lcdc_slot_timer #(
        .DUTY(DUTY),
        .FRAME_DIV(FRAME_DIV)
    ) u_slot (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .run_i(drive_on),
        .slot_o(slot),
        .frame_o()
    );

    // Map entry layout: bits 7..2 pick the memory word, bits 1..0 pick
    // the bit within it. An all-zero map stands for the linear layout in
    // which pin p uses word p and common c uses bit c. A word index past
    // the end of the array wraps rather than reading outside it.
    // Memory bit lookup for a pin and common; linear when map is zero
    function automatic logic seg_bit(input int pin, input logic [1:0] c);
        logic [7:0] m;
        int lin;
        m = SEG_MAP[pin * 4 + int'(c)];
        lin = pin * 4 + int'(c);
        if (SEG_MAP == '0) begin
            m = 8'(lin);
        end
        seg_bit = mem[m[7:2] % 48][m[1:0]];
    endfunction

    // DC pins ignore the drive switch: they show their common 0 bit at
    // all times, so an all-off panel can still carry static indicators.
    // Every other pin is forced to the off level while drive is off.
    // Per-pin segment and DC logic
    genvar gi;
    generate
        for (gi = 0; gi < lcdc_pkg::NUM_SEG; gi++) begin : g_seg
            localparam bit IS_DC = DC_PAIRS[gi / 2];
            always_comb begin
                if (IS_DC) begin
                    seg_next[gi] = seg_bit(gi, 2'h0);
                end else if (!drive_on) begin
                    seg_next[gi] = lcdc_pkg::OFF_LEVEL;
                end else begin
                    seg_next[gi] = seg_bit(gi, slot);
                end
            end
            // An open-drain pin only pulls low; a one leaves it released
            // Open drain floats on high, push-pull always drives
            assign segment_oe_n_o[gi] = (IS_DC && DC_OPEN_DRAIN[gi]) ?
                seg_reg[gi] : 1'b0;
            assign segment_dc_o[gi] = IS_DC;
        end
    endgenerate

    // Commons above the duty are never selected because the slot counter
    // wraps at the last used common.
    // Active common marker, one-hot per slot
    always_comb begin
        com_next = 4'h0;
        if (drive_on) begin
            com_next[slot] = 1'b1;
        end
    end

    // Registering both commons and segments keeps them changing on the
    // same edge, so the panel never sees a slot with stale segment data.
    // The cost is one cycle of lag behind the slot counter.
    // Reset clears the panel outputs together with the switch, so the
    // first edges after reset already show the all-off levels.
    // Panel output flops; non-DC pins constant while all-off
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            com_reg <= 4'h0;
            seg_reg <= 38'h0000000000;
        end else begin
            com_reg <= com_next;
            seg_reg <= seg_next;
        end
    end

    assign common_outputs_o = com_reg;
    assign segment_outputs_o = seg_reg;
    // Purely a build constant; the panel side uses it to park unused
    // commons.
    // Commons in use for this duty
    assign common_active_o = (DUTY == 2) ? 4'h3 : (DUTY == 3) ? 4'h7 : 4'hF;
endmodule
`default_nettype wire

// File: sim/lcdc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// Panel stand-in: counts frames by the start of common 0
module lcdc_panel_model (
    // Clock
    input wire logic clk_i,
    // Commons from the controller
    input wire logic [3:0] common_outputs_i,
    // Frames seen so far
    output var int frames_o
);
    logic [3:0] last_com = 4'h0; // Common seen one edge ago
    initial frames_o = 0;
    // A frame starts when common 0 takes over the slot
    always @(posedge clk_i) begin
        if (common_outputs_i == 4'h1 && last_com != 4'h1) begin
            frames_o <= frames_o + 1;
        end
        last_com <= common_outputs_i;
    end
endmodule
`default_nettype wire

// File: sim/lcdc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the display controller
module lcdc_top_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Bus
    input wire logic [7:0] cpu_addr_i,
    input wire logic [3:0] cpu_wdata_i,
    input wire logic cpu_wr_i,
    input wire logic cpu_rd_i,
    input wire logic [3:0] cpu_rdata_o,
    input wire logic cpu_hit_o,
    // Panel
    input wire logic [3:0] common_outputs_o,
    input wire logic [3:0] common_active_o
);
    logic [3:0] prev_reg; // Common one edge ago
    logic [9:0] cnt_reg; // Edges since the common last moved
    logic sw_wr; // Write to the switch register
    logic mv; // Slot moved between two driven commons
    assign sw_wr = cpu_wr_i && cpu_addr_i == 8'h78;
    assign mv = common_outputs_o != prev_reg && prev_reg != 4'h0
        && common_outputs_o != 4'h0;
    // Slot length counter; a plain count, since a repetition can't be 256
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev_reg <= 4'h0;
            cnt_reg <= 10'h000;
        end else begin
            prev_reg <= common_outputs_o;
            cnt_reg <= (common_outputs_o != prev_reg) ? 10'h000 :
                cnt_reg + 10'h001;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_on;
        sw_wr && cpu_wdata_i[3] && common_outputs_o == 4'h0;
    endsequence
    sequence s_off; sw_wr && !cpu_wdata_i[3] ##1 !sw_wr; endsequence
    property p_on; s_on |-> ##2 common_outputs_o == 4'h1; endproperty
    property p_off; s_off |-> ##1 (common_outputs_o == 4'h0) [*3]; endproperty
    property p_slot; mv |-> cnt_reg == 10'h0FF; endproperty
    property p_rot;
        mv |-> common_outputs_o == {prev_reg[2:0], prev_reg[3]};
    endproperty
    property p_one; $onehot0(common_outputs_o); endproperty
    property p_hit; cpu_hit_o == (cpu_addr_i == 8'h78
        || cpu_addr_i inside {[8'h40:8'h6F]}); endproperty
    property p_miss; cpu_rd_i && !cpu_hit_o |=> cpu_rdata_o == 4'h0; endproperty
    property p_act; common_active_o == 4'hF; endproperty
    a_on: assert property (p_on) else $error("drive on missed");
    a_off: assert property (p_off) else $error("all-off missed");
    a_slot: assert property (p_slot) else $error("slot length");
    a_rot: assert property (p_rot) else $error("common order");
    a_one: assert property (p_one) else $error("commons overlap");
    a_hit: assert property (p_hit) else $error("decode wrong");
    a_miss: assert property (p_miss) else $error("miss read data");
    a_act: assert property (p_act) else $error("duty mask");
endmodule
bind lcdc_top lcdc_top_chk chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wdata_i(cpu_wdata_i), .cpu_wr_i(cpu_wr_i),
    .cpu_rd_i(cpu_rd_i), .cpu_rdata_o(cpu_rdata_o), .cpu_hit_o(cpu_hit_o),
    .common_outputs_o(common_outputs_o), .common_active_o(common_active_o));
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the display controller
module tb_top;
    logic clk_i = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [3:0] wd = 4'h0, rdat, com, act;
    logic [37:0] seg, oe_n, dc, seg2, oe2, dc2;
    logic [2:0] tick;
    logic hit;
    int mismatches = 0, n_compared = 0, frames, cyc = 0, t0, f0;
    int mem [48]; // Model of the display memory
    lcdc_top dut_u (.clk_i(clk_i), .sys_rst_i(rst), .cpu_addr_i(addr),
        .cpu_wdata_i(wd), .cpu_wr_i(wr_s), .cpu_rd_i(rd_s), .cpu_rdata_o(rdat),
        .cpu_hit_o(hit), .common_outputs_o(com), .common_active_o(act),
        .segment_outputs_o(seg), .segment_oe_n_o(oe_n), .segment_dc_o(dc),
        .tick_irq_en_o(tick));
    // Second build with pair 0 as DC outputs, pin 1 open drain
    lcdc_top #(.DC_PAIRS(19'h00001), .DC_OPEN_DRAIN(38'h0000000002)) dc_u (
        .clk_i(clk_i), .sys_rst_i(rst), .cpu_addr_i(addr),
        .cpu_wdata_i(wd), .cpu_wr_i(wr_s), .cpu_rd_i(rd_s), .cpu_rdata_o(),
        .cpu_hit_o(), .common_outputs_o(), .common_active_o(),
        .segment_outputs_o(seg2), .segment_oe_n_o(oe2),
        .segment_dc_o(dc2), .tick_irq_en_o());
    lcdc_panel_model pan_u (.clk_i(clk_i), .common_outputs_i(com),
        .frames_o(frames));
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    // Compare seen against expected
    task automatic check(input logic [37:0] seen, input logic [37:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic test_done;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One write strobe, driven on the falling edge
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        @(negedge clk_i);
        addr = a;
        wd = d;
        wr_s = 1'b1;
        @(negedge clk_i);
        wr_s = 1'b0;
    endtask
    // One read; data is registered, so look a cycle later
    task automatic rd(input logic [7:0] a, input logic [3:0] e);
        @(negedge clk_i);
        addr = a;
        rd_s = 1'b1;
        @(negedge clk_i);
        rd_s = 1'b0;
        check(rdat, e);
    endtask
    // Bounded wait for a given common
    task automatic wait_com(input logic [3:0] v);
        for (int i = 0; i < 2000 && com !== v; i++) @(negedge clk_i);
        if (com !== v) begin
            check(com, v);
            test_done();
        end
    endtask
    initial begin
        int i, c;
        logic [37:0] exp;
        void'($urandom(32'hcf2d));
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rst = 1'b0;
        rd(8'h78, 4'h0);
        check(com, 4'h0);
        for (i = 0; i < 48; i++) begin
            mem[i] = $urandom % 16;
            wr(8'h40 + i[7:0], mem[i][3:0]);
        end
        for (i = 0; i < 48; i++) rd(8'h40 + i[7:0], mem[i][3:0]);
        wr(8'hC5, 4'hF);
        rd(8'hC5, 4'h0);
        rd(8'h45, mem[5][3:0]);
        c = 8 + $urandom % 8;
        wr(8'h78, c[3:0]);
        rd(8'h78, c[3:0]);
        check(tick, c[2:0]);
        wait_com(4'h2);
        wait_com(4'h1);
        t0 = cyc;
        f0 = frames;
        for (c = 0; c < 4; c++) begin
            wait_com(4'h1 << c);
            repeat (128) @(negedge clk_i);
            for (i = 0; i < 38; i++) exp[i] = mem[i][c];
            check(seg, exp);
            check(seg2[37:2], exp[37:2]);
            check(seg2[1:0], {mem[1][0], mem[0][0]});
        end
        wait_com(4'h1);
        check(38'(cyc - t0), 38'd1024);
        check(38'(frames - f0), 38'd1);
        wr(8'h78, 4'h0);
        repeat (2) @(negedge clk_i);
        check(com, 4'h0);
        check(seg, 38'h0);
        check(seg2, {36'h0, mem[1][0], mem[0][0]});
        check(oe2, {36'h0, mem[1][0], 1'b0});
        check(dc2, 38'h3);
        check(dc, 38'h0);
        check(oe_n, 38'h0);
        check(act, 4'hF);
        rst = 1'b1;
        repeat (3) @(negedge clk_i);
        rst = 1'b0;
        rd(8'h78, 4'h0);
        rd(8'h4A, mem[10][3:0]);
        test_done();
    end
endmodule
`default_nettype wire
